// [lsd_pkg.sv]
// Package for the seven-to-one serial link receiver.
// Assumes a 100 MHz ref_clk; all counts below are in ref_clk cycles.
`default_nettype none
package lsd_pkg;
	// Link geometry
	localparam int LANES = 3;
	localparam int SLOTS = 7;
	localparam int WORD_W = 21;
	localparam int FIFO_DEPTH = 8;
	// Reference clock
	localparam int REF_PERIOD_PS = 10000;
	// Forwarded clock limits and nominal slot sample points at 75 MHz
	localparam int OUT_PERIOD_MIN_PS = 13330;
	localparam int OUT_PERIOD_MAX_PS = 50000;
	localparam int OUT_HIGH_MIN_PS = 3600;
	localparam int OUT_HIGH_MAX_PS = 6000;
	localparam int CLOCK_THROUGH_MIN_PS = 3400;
	localparam int CLOCK_THROUGH_MAX_PS = 7300;
	localparam int SLOT0_SAMPLE_PS = 950;
	localparam int SLOT6_SAMPLE_PS = 12380;
	localparam int SAMPLING_MARGIN_PS = 380;
	localparam int SOURCE_JITTER_PS = 250;
	// Lock time, longest, rounded down
	localparam int PLL_LOCK_TIME_MS = 10;
	localparam int PLL_LOCK_CYCLES = (PLL_LOCK_TIME_MS * 1000000) / (REF_PERIOD_PS / 1000);
	// Powerdown entry, longest, rounded down
	localparam int POWERDOWN_DELAY_US = 1;
	localparam int POWERDOWN_CYCLES = (POWERDOWN_DELAY_US * 1000000) / REF_PERIOD_PS;
	// Counter widths and reset values
	localparam int CNT_W = 8;
	localparam int LOCK_W = 20;
	localparam logic [CNT_W-1:0] CLK_LOSS_CYCLES = 8'h40;
	localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
	localparam logic [WORD_W-1:0] WORD_RESET = 21'h000000;
	localparam logic [2:0] SLOT_DONE = 3'h7;

	// Cycle after the clock edge at which slot k is centred
	function automatic logic [CNT_W-1:0] slot_pos(input logic [CNT_W-1:0] per,
		input logic [2:0] k);
		logic [CNT_W+3:0] prod;
		logic [CNT_W-1:0] pos;
		prod = per * {k, 1'b1};
		pos = CNT_W'(prod / 12'h00e);
		return (pos == 8'h00) ? 8'h01 : pos;
	endfunction
endpackage
`default_nettype wire

// [lsd_rx.sv]
// Seven-to-one serial link receiver: word FIFO and receiver top level.
// Assumes lanes and forwarded clock arrive as already-decoded levels from
// the differential input buffers, asynchronous to ref_clk.
`timescale 1ns/10ps
`default_nettype none

// Word FIFO, flip-flop storage, data out read combinationally at the read pointer
module lsd_fifo
	import lsd_pkg::*;
#(
	parameter int W = WORD_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [AW:0] cnt;
	} lsd_fifo_state_t;

	lsd_fifo_state_t st_q;
	lsd_fifo_state_t st_d;
	logic do_wr;
	logic do_rd;

	// Honest flags straight from the count
	assign in_ready = (st_q.cnt != FULL_CNT);
	assign out_valid = (st_q.cnt != '0);
	assign out_data = st_q.mem[st_q.rp];
	assign do_wr = in_valid & in_ready;
	assign do_rd = out_valid & out_ready;

	// Pointer and count update
	always_comb begin
		st_d = st_q;
		if (do_wr) begin
			st_d.mem[st_q.wp] = in_data;
			st_d.wp = AW'(st_q.wp + 1'b1);
		end
		if (do_rd) begin
			st_d.rp = AW'(st_q.rp + 1'b1);
		end
		st_d.cnt = (AW+1)'(st_q.cnt + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd});
		if (flush) begin
			st_d.wp = '0;
			st_d.rp = '0;
			st_d.cnt = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
endmodule

// Function
// RL1: Three serial lanes in, 21 parallel outputs, updated once per forwarded period.
// RL2: Seven slots sampled per lane each forwarded period, spread across the period.
// RL3: Each slot lasts one seventh of the forwarded clock period.
// RL4: Output strobe rising edge marks valid data; downstream captures on it.
// RL5: Output strobe period follows forwarded clock, 13.33 ns to 50 ns; code only handles 10 to 63 ref_clk cycles (100 ns to 630 ns).
// RL6: Strobe high phase about half the period, nominally balanced duty.
// RL7: Each word appears two forwarded periods after arrival.
// RL8: Lock within 10 ms of clock; no output before lock.
// RL9: Powerdown low forces every output low.
// RL10: Outputs reach low within 1 us of powerdown.
// RL11: Idle-high lanes with clock present give all-ones data.
// RL12: Lanes and clock both idle: data holds last valid word.
// RL13: Forwarded clock idle: strobe held low.
// RL14: Keep at least 380 ps valid sampling region per slot.
// RL15: Transmitter keeps forwarded clock jitter below 250 ps.
// RL16: Lane L slot s carries output bit 7L+s, fixed order.
module lsd_rx
	import lsd_pkg::*;
#(
	parameter int LOCK_CYCLES = PLL_LOCK_CYCLES
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [LANES-1:0] serial_data_lane_in,
	input wire logic forwarded_clock_in,
	input wire logic powerdown_n,
	output logic [WORD_W-1:0] parallel_data_out,
	output logic parallel_strobe_clock_out
);
	typedef struct packed {
		logic fck_m;
		logic fck_s;
		logic fck_p;
		logic [LANES-1:0] lane_m;
		logic [LANES-1:0] lane_s;
		logic pdn_m;
		logic pdn_s;
		logic [CNT_W-1:0] per_cnt;
		logic [CNT_W-1:0] per;
		logic [LOCK_W-1:0] lock_cnt;
		logic locked;
		logic [2:0] slot;
		logic [WORD_W-1:0] acc;
		logic [WORD_W-1:0] dout;
		logic stb;
		logic [CNT_W-1:0] hi_cnt;
	} lsd_rx_state_t;

	localparam logic [LOCK_W-1:0] LOCK_LAST = LOCK_W'(LOCK_CYCLES - 1);

	lsd_rx_state_t st_q;
	lsd_rx_state_t st_d;
	logic fck_edge;
	logic clk_ok;
	logic push;
	logic pop;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [WORD_W-1:0] fifo_out_data;
	logic fifo_flush;

	// Edge of the synchronised forwarded clock, and its presence
	assign fck_edge = st_q.fck_s & ~st_q.fck_p;
	assign clk_ok = (st_q.per_cnt < CLK_LOSS_CYCLES);
	// Frame closes on the next edge; a short frame is dropped
	assign push = fck_edge & st_q.locked & (st_q.slot == SLOT_DONE); // [RL1]
	// One word leaves per forwarded edge, so output rate tracks it
	// An edge that comes after the loss timeout counts as no clock, so nothing leaves then
	assign pop = fck_edge & st_q.locked & clk_ok & st_q.pdn_s & fifo_out_valid; // [RL5] [RL7]
	// Stale words must not leak out after a relock
	assign fifo_flush = ~st_q.pdn_s | ~st_q.locked;

	// Word buffer between frame assembly and output strobe
	lsd_fifo #(
		.W(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) i_lsd_fifo (
		.clk(ref_clk),
		.rst(sys_rst),
		.flush(fifo_flush),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data(st_q.acc),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data(fifo_out_data)
	);

	// Next-state logic for the whole receiver
	always_comb begin
		st_d = st_q;
		// Two-stage synchronisers; logic reads only stage two and its fck_p edge-detect copy
		st_d.fck_m = forwarded_clock_in;
		st_d.fck_s = st_q.fck_m;
		st_d.fck_p = st_q.fck_s;
		st_d.lane_m = serial_data_lane_in;
		st_d.lane_s = st_q.lane_m;
		st_d.pdn_m = powerdown_n;
		st_d.pdn_s = st_q.pdn_m;

		// Period measurement, saturating so a stopped clock is seen
		if (fck_edge) begin
			st_d.per = st_q.per_cnt;
			st_d.per_cnt = 8'h01;
			st_d.slot = 3'h0;
		end else if (st_q.per_cnt != CNT_MAX) begin
			st_d.per_cnt = CNT_W'(st_q.per_cnt + 8'h01);
		end

		// Slot sampling at odd fourteenths of the period, slot centres
		if (!fck_edge && st_q.slot != SLOT_DONE &&
			st_q.per_cnt == slot_pos(st_q.per, st_q.slot)) begin // [RL2] [RL3] [RL14]
			for (int l = 0; l < LANES; l++) begin
				st_d.acc[5'(l * SLOTS) + 5'(st_q.slot)] = st_q.lane_s[l]; // [RL16] [RL11]
			end
			st_d.slot = 3'(st_q.slot + 3'h1);
		end

		// Lock after a run of continuous clock; lost with clock or power
		if (!st_q.pdn_s || !clk_ok) begin
			st_d.lock_cnt = '0;
			st_d.locked = 1'b0;
		end else if (!st_q.locked) begin // [RL8]
			st_d.lock_cnt = LOCK_W'(st_q.lock_cnt + 1'b1);
			if (st_q.lock_cnt == LOCK_LAST) begin
				st_d.locked = 1'b1;
			end
		end

		// Strobe: data changes with the rising edge, high for half a period
		if (pop) begin
			st_d.dout = fifo_out_data; // [RL4]
			st_d.stb = 1'b1;
			st_d.hi_cnt = (st_q.per[CNT_W-1:1] == '0) ? 8'h01 : {1'b0, st_q.per[CNT_W-1:1]};
		end else if (st_q.stb) begin // [RL6]
			st_d.hi_cnt = CNT_W'(st_q.hi_cnt - 8'h01);
			if (st_q.hi_cnt <= 8'h01) begin
				st_d.stb = 1'b0;
			end
		end

		// Idle clock: strobe low, data keeps the last word
		if (!clk_ok) begin
			st_d.stb = 1'b0; // [RL13] [RL12]
		end
		// Powerdown overrides everything
		if (!st_q.pdn_s) begin
			st_d.dout = WORD_RESET; // [RL9] [RL10]
			st_d.stb = 1'b0;
		end
	end

	// Link clock idles high; seeding the detector high avoids a false edge after reset
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q <= '0;
			st_q.fck_m <= 1'b1;
			st_q.fck_s <= 1'b1;
			st_q.fck_p <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs come straight from flops
	assign parallel_data_out = st_q.dout;
	assign parallel_strobe_clock_out = st_q.stb;

	// Powerdown held long enough forces both outputs low
	chk_pdn_outputs_low: assert property ( // [RL9]
		@(posedge ref_clk) disable iff (sys_rst)
		(!powerdown_n) [*4] |-> (parallel_data_out == '0) && !parallel_strobe_clock_out)
		else $error("outputs not low in powerdown");

	// Pin fall to low outputs: two sync stages and one register, far inside 1 us
	chk_pdn_entry_delay: assert property ( // [RL10]
		@(posedge ref_clk) disable iff (sys_rst)
		$fell(powerdown_n) |-> ##3 (parallel_data_out == '0) && !parallel_strobe_clock_out)
		else $error("powerdown entry too slow");

	// No strobe while the forwarded clock is missing
	chk_noclk_strobe_low: assert property ( // [RL13]
		@(posedge ref_clk) disable iff (sys_rst)
		!clk_ok |=> !parallel_strobe_clock_out)
		else $error("strobe active without clock");

	// Missing clock with power on keeps the last word
	chk_noclk_hold_word: assert property ( // [RL12]
		@(posedge ref_clk) disable iff (sys_rst)
		!clk_ok && st_q.pdn_s && !fck_edge |=> $stable(parallel_data_out))
		else $error("data moved without clock");

	// Outside powerdown, data only changes with a strobe rising edge
	chk_strobe_data_stable: assert property ( // [RL4]
		@(posedge ref_clk) disable iff (sys_rst)
		$past(st_q.pdn_s) && !$rose(parallel_strobe_clock_out) |-> $stable(parallel_data_out))
		else $error("data changed away from strobe edge");

	// High phase lasts at least two cycles for a usable period, unless powerdown cuts it
	chk_strobe_high_phase: assert property ( // [RL6]
		@(posedge ref_clk) disable iff (sys_rst)
		pop && st_q.per >= 8'h04 |=> parallel_strobe_clock_out ##1
		(parallel_strobe_clock_out || !$past(st_q.pdn_s)))
		else $error("strobe high phase too short");

	// A strobe never rises before lock
	chk_lock_before_out: assert property ( // [RL8]
		@(posedge ref_clk) disable iff (sys_rst)
		$rose(parallel_strobe_clock_out) |-> $past(st_q.locked))
		else $error("strobe before lock");

	// Popped word reaches the outputs one cycle later
	chk_word_to_out: assert property ( // [RL1]
		@(posedge ref_clk) disable iff (sys_rst)
		pop |=> parallel_data_out == $past(fifo_out_data))
		else $error("popped word not presented");

	// A full-length frame collects all seven slots
	chk_slot_count: assert property ( // [RL2]
		@(posedge ref_clk) disable iff (sys_rst)
		fck_edge && st_q.locked && st_q.per >= 8'h0e && st_q.per_cnt == st_q.per
		|-> st_q.slot == SLOT_DONE)
		else $error("frame missed a slot");

	// At most one word waits, so the buffer never refuses a finished frame
	chk_fifo_never_full: assert property ( // [RL7]
		@(posedge ref_clk) disable iff (sys_rst)
		push |-> fifo_in_ready)
		else $error("word buffer full at frame end");
endmodule
`default_nettype wire

// [lsd_tx_model.sv]
// Serializing transmitter model: three lanes plus forwarded clock.
// Assumes the bench calls its tasks; idle lines float high.
`timescale 1ns/10ps
`default_nettype none
module lsd_tx_model
	import lsd_pkg::*;
(
	output logic [LANES-1:0] lane_o,
	output logic fclk_o
);
	// Failsafe bias: released lines read high
	initial begin
		lane_o = '1;
		fclk_o = 1'b1;
	end
	// One frame; a steady period keeps jitter at zero
	task automatic send_frame(input logic [WORD_W-1:0] w, input realtime per);
		for (int s = 0; s < SLOTS; s++) begin
			for (int l = 0; l < LANES; l++) begin
				lane_o[l] <= w[SLOTS*l+s];
			end
			if (s == 0) begin
				fclk_o <= 1'b1;
			end
			if (s == 3) begin
				#(per / 14.0) fclk_o <= 1'b0;
				#(per / 14.0);
			end else begin
				#(per / 7.0);
			end
		end
	endtask
	// Going idle raises the clock, which closes the last frame
	task automatic idle();
		lane_o <= '1;
		fclk_o <= 1'b1;
	endtask
endmodule
`default_nettype wire

// [tb_lsd_rx.sv]
// Testbench for the serial link receiver top level.
// Assumes lsd_pkg and lsd_tx_model; short lock count for speed.
`timescale 1ns/10ps
`default_nettype none
module tb_lsd_rx;
	import lsd_pkg::*;
	localparam realtime PER = 160.0;
	logic ref_clk, sys_rst, powerdown_n, strobe, st_q, skip, live, fclk;
	logic [LANES-1:0] lanes;
	logic [WORD_W-1:0] dout, exp_w, last_w;
	logic [WORD_W-1:0] expq[$];
	logic [WORD_W-1:0] corner[5] = '{21'h1fffff, 21'h000001, 21'h100000, 21'h155555, 21'h0aaaaa};
	int err_count, num_checks, hcnt, pcnt;

	lsd_rx #(.LOCK_CYCLES(40)) i_lsd_rx (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.serial_data_lane_in(lanes), .forwarded_clock_in(fclk), .powerdown_n(powerdown_n),
		.parallel_data_out(dout), .parallel_strobe_clock_out(strobe));
	lsd_tx_model i_lsd_tx_model (.lane_o(lanes), .fclk_o(fclk));

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	task automatic check_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// Each strobe rise must deliver the next queued word; zeros skipped while warming
	always @(posedge ref_clk) begin
		if (strobe === 1'b1 && st_q !== 1'b1) begin
			if (!(skip && dout === '0)) begin
				skip = 1'b0;
				exp_w = (expq.size() > 0) ? expq.pop_front() : ~dout;
				check_word(dout, exp_w);
				// Back-to-back strobes repeat at the forwarded period, 16 cycles
				if (pcnt < 40) begin
					check_word(WORD_W'(pcnt), 21'h000010);
				end
			end
			hcnt = 0;
			pcnt = 0;
		end
		pcnt++;
		if (strobe === 1'b1) hcnt++;
		else if (st_q === 1'b1 && !skip) check_word(WORD_W'(hcnt), 21'h000008);
		st_q = strobe;
	end

	task automatic send_w(input logic [WORD_W-1:0] w);
		if (live) begin
			expq.push_back(w);
			last_w = w;
		end
		i_lsd_tx_model.send_frame(w, PER);
	endtask
	// Random nonzero words, so warm-up zeros stay distinguishable
	task automatic rnd(input int n);
		logic [WORD_W-1:0] w;
		for (int i = 0; i < n; i++) begin
			w = WORD_W'($urandom);
			if (w === '0) w = 21'h000001;
			send_w(w);
		end
	endtask
	// Zero frames until lock; their output is not predicted
	task automatic warm();
		live = 1'b0;
		skip = 1'b1;
		for (int i = 0; i < 6; i++) send_w('0);
		live = 1'b1;
	endtask
	// The last real word needs two more edges; an unexpected frame and the idle rise provide them
	task automatic tail();
		live = 1'b0;
		send_w('1);
		i_lsd_tx_model.idle();
	endtask

	// Watchdog: all tests need roughly 13 us
	initial begin
		#100us;
		err_count++;
		$display("BAD t=%0t watchdog %h %h", $time, expq.size(), 0);
		test_done();
	end

	initial begin
		sys_rst = 1'b1;
		powerdown_n = 1'b1;
		{skip, live, st_q} = 3'h0;
		{err_count, num_checks, hcnt} = '0;
		pcnt = 1000;
		last_w = '0;
		void'($urandom(73));
		repeat (12) @(posedge ref_clk);
		sys_rst <= 1'b0;
		// Corners (all-ones mimics idle-high lanes), random, then clock loss
		warm();
		foreach (corner[i]) send_w(corner[i]);
		rnd(20);
		tail();
		repeat (120) @(posedge ref_clk);
		check_word(WORD_W'(expq.size()), '0);
		check_bit(strobe, 1'b0);
		check_word(dout, last_w);
		$display("test stream and clock loss done");
		// Powerdown in mid-stream drops words in flight
		warm();
		fork
			rnd(14);
			begin
				repeat (60) @(posedge ref_clk);
				live = 1'b0;
				powerdown_n <= 1'b0;
				repeat (5) @(posedge ref_clk);
				expq.delete();
				check_word(dout, '0);
				check_bit(strobe, 1'b0);
				repeat (90) @(posedge ref_clk);
				check_word(dout, '0);
			end
		join
		@(posedge ref_clk) powerdown_n <= 1'b1;
		warm();
		rnd(6);
		tail();
		repeat (120) @(posedge ref_clk);
		check_word(WORD_W'(expq.size()), '0);
		check_word(dout, last_w);
		$display("test powerdown done");
		test_done();
	end
endmodule
`default_nettype wire
